/* rtl/vtei_top.v */
// interrupt vector table control and external interrupt groups, ahb-lite slave
//
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "vtei_map.vh"

module vtei_top #(
	parameter NGRP = 5,
	parameter W    = 8
) (
	// clock and reset
	input  wire                ref_clk,
	input  wire                rst,
	// ahb-lite slave
	input  wire                hsel,
	input  wire [7:0]          haddr,
	input  wire [1:0]          htrans,
	input  wire                hwrite,
	input  wire [2:0]          hsize,
	input  wire [31:0]         hwdata,
	input  wire                hready,
	output reg                 hreadyout_ff,
	output reg                 hresp_ff,
	output reg  [31:0]         hrdata_ff,
	// port pins
	input  wire [NGRP*W-1:0]   ext_pins,
	// peripheral requests, same clock
	input  wire                usb_irq,
	input  wire                usb_suspend_end_irq,
	input  wire                storage_card_irq,
	input  wire                spi_irq,
	input  wire                timer_irq,
	input  wire                time_base_irq,
	// cpu core side
	input  wire                cpu_halted,
	input  wire                cpu_trap,
	input  wire                cpu_ack,
	input  wire                cpu_rim,
	input  wire                cpu_sim,
	input  wire                cpu_halt_wfi,
	input  wire                cpu_cc_wr,
	input  wire [7:0]          cpu_cc_wdata,
	output reg                 irq_req_ff,
	output reg                 irq_trap_ff,
	output reg  [3:0]          irq_slot_ff,
	output reg  [15:0]         vec_addr_ff,
	output reg                 wake_ff,
	output reg  [7:0]          cc_out_ff
);

	// ------------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------------
	// numeric level of a two-bit priority code
	function [1:0] prio_level;
		input [1:0] code;
		begin
			case (code)
				2'h2:    prio_level = 2'h0;
				2'h1:    prio_level = 2'h1;
				2'h0:    prio_level = 2'h2;
				default: prio_level = 2'h3;
			endcase
		end
	endfunction

	// merge a priority byte write, refusing the level 0 code per field
	function [7:0] ispr_merge;
		input [7:0] old;
		input [7:0] wr;
		integer     k;
		begin
			ispr_merge = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (wr[2*k +: 2] != `VTEI_PRIO_LVL0)
					ispr_merge[2*k +: 2] = wr[2*k +: 2];
			end
		end
	endfunction

	// ------------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------------
	reg              remap_ff;
	reg  [31:0]      ispr_ff;
	reg  [2*NGRP-1:0] sens_ff;
	reg  [NGRP*W-1:0] ena_ff;
	reg  [7:0]       cc_ff;
	reg              trap_pend_ff;
	reg              rd_pend_ff;
	reg              wr_pend_ff;
	reg  [7:0]       addr_ff;

	wire [NGRP*W-1:0] flags_w;
	wire [NGRP-1:0]   greq_w;
	wire              cc_level3;
	wire [1:0]        cur_lvl;
	wire              wr_now;
	wire [7:0]        wbyte;
	wire              sens_wr_ok;
	reg  [NGRP-1:0]   grp_clr;
	reg  [NGRP-1:0]   flg_wr;
	reg  [31:0]       rd_mux;
	wire [7:0]        ispr3_m;

	assign cc_level3 = cc_ff[`VTEI_CC_HI_BIT] & cc_ff[`VTEI_CC_LO_BIT];
	assign cur_lvl   = prio_level({cc_ff[`VTEI_CC_HI_BIT], cc_ff[`VTEI_CC_LO_BIT]});
	assign wr_now    = wr_pend_ff;
	assign wbyte     = hwdata[7:0];
	assign ispr3_m   = ispr_merge(ispr_ff[31:24], wbyte);
	// refused writes vanish silently; the bus still answers okay
	assign sens_wr_ok = wr_now & cc_level3;

	// ------------------------------------------------------------------------
	// ahb-lite slave: writes zero wait, reads one wait state
	// ------------------------------------------------------------------------
	// reads wait a cycle so a read right after a write sees the new value
	always @(posedge ref_clk) begin
		if (rst) begin
			hreadyout_ff <= 1'b1;
			hresp_ff     <= 1'b0;
			hrdata_ff    <= 32'h00000000;
			rd_pend_ff   <= 1'b0;
			wr_pend_ff   <= 1'b0;
			addr_ff      <= 8'h00;
		end else begin
			wr_pend_ff <= 1'b0;
			if (rd_pend_ff) begin
				hrdata_ff    <= rd_mux;
				hreadyout_ff <= 1'b1;
				rd_pend_ff   <= 1'b0;
			end else if (hsel && hready && htrans[1]) begin
				addr_ff <= haddr;
				if (hwrite) begin
					wr_pend_ff <= 1'b1;
				end else begin
					rd_pend_ff   <= 1'b1;
					hreadyout_ff <= 1'b0;
				end
			end
		end
	end

	// read mux; unmapped offsets read zero
	always @* begin
		rd_mux = 32'h00000000;
		case (addr_ff)
			`VTEI_OFF_MISC:  rd_mux[`VTEI_MISC_REMAP_BIT] = remap_ff;
			`VTEI_OFF_ISPR0: rd_mux[7:0] = ispr_ff[7:0];
			`VTEI_OFF_ISPR1: rd_mux[7:0] = ispr_ff[15:8];
			`VTEI_OFF_ISPR2: rd_mux[7:0] = ispr_ff[23:16];
			`VTEI_OFF_ISPR3: rd_mux[7:0] = ispr_ff[31:24] | `VTEI_ISPR3_RO_MASK;
			`VTEI_OFF_EICR0: rd_mux[7:0] = sens_ff[7:0];
			`VTEI_OFF_EICR1: rd_mux[1:0] = sens_ff[9:8];
			`VTEI_OFF_CC:    rd_mux[7:0] = cc_ff;
			default: begin
				if (addr_ff >= `VTEI_OFF_ENA_BASE && addr_ff < `VTEI_OFF_FLG_BASE)
					rd_mux[7:0] = ena_ff[W*((addr_ff - `VTEI_OFF_ENA_BASE) >> 2) +: W];
				else if (addr_ff >= `VTEI_OFF_FLG_BASE && addr_ff < `VTEI_OFF_CC)
					rd_mux[7:0] = flags_w[W*((addr_ff - `VTEI_OFF_FLG_BASE) >> 2) +: W];
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------------------
	// remap, priorities, sensitivities and enables
	always @(posedge ref_clk) begin
		if (rst) begin
			remap_ff <= 1'b0;
			ispr_ff  <= `VTEI_ISPR_RST;
			sens_ff  <= {2*NGRP{1'b0}};
			ena_ff   <= {NGRP*W{1'b0}};
		end else if (wr_now) begin
			case (addr_ff)
				`VTEI_OFF_MISC:  remap_ff <= wbyte[`VTEI_MISC_REMAP_BIT];
				`VTEI_OFF_ISPR0: ispr_ff[7:0]   <= ispr_merge(ispr_ff[7:0], wbyte);
				`VTEI_OFF_ISPR1: ispr_ff[15:8]  <= ispr_merge(ispr_ff[15:8], wbyte);
				`VTEI_OFF_ISPR2: ispr_ff[23:16] <= ispr_merge(ispr_ff[23:16], wbyte);
				`VTEI_OFF_ISPR3: ispr_ff[27:24] <= ispr3_m[3:0]; // upper nibble read-only
				`VTEI_OFF_EICR0: if (sens_wr_ok) sens_ff[7:0] <= wbyte;
				`VTEI_OFF_EICR1: if (sens_wr_ok) sens_ff[9:8] <= wbyte[1:0];
				default: begin
					if (addr_ff >= `VTEI_OFF_ENA_BASE && addr_ff < `VTEI_OFF_FLG_BASE)
						ena_ff[W*((addr_ff - `VTEI_OFF_ENA_BASE) >> 2) +: W] <= wbyte;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// external groups
	// ------------------------------------------------------------------------
	// per group: flag write strobes and pending clears
	always @* begin : grp_ctl
		integer g;
		g       = 0;
		grp_clr = {NGRP{1'b0}};
		flg_wr  = {NGRP{1'b0}};
		for (g = 0; g < NGRP; g = g + 1) begin
			flg_wr[g] = wr_now && (addr_ff == `VTEI_OFF_FLG_BASE + 4*g);
			// changing the sensitivity drops stale pending events
			if (sens_wr_ok && (addr_ff == ((g < 4) ? `VTEI_OFF_EICR0 : `VTEI_OFF_EICR1))
			    && (wbyte[2*(g%4) +: 2] != sens_ff[2*g +: 2]))
				grp_clr[g] = 1'b1;
			// edge requests are consumed at entry; level ones persist
			if (cpu_ack && !irq_trap_ff && irq_slot_ff == `VTEI_SLOT_EXT0 + g
			    && sens_ff[2*g +: 2] != `VTEI_SENS_FALL_LOW)
				grp_clr[g] = 1'b1;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NGRP; gi = gi + 1) begin : grp
			vtei_ext_group #(.W(W)) u_grp (
				.ref_clk    (ref_clk),
				.rst        (rst),
				.pins       (ext_pins[W*gi +: W]),
				.sens       (sens_ff[2*gi +: 2]),
				.enable     (ena_ff[W*gi +: W]),
				.flag_wr    (flg_wr[gi]),
				.flag_wdata (wbyte),
				.clr_all    (grp_clr[gi]),
				.flags_ff   (flags_w[W*gi +: W]),
				.req        (greq_w[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------------------
	// arbitration
	// ------------------------------------------------------------------------
	reg [11:0] pend;
	reg [11:0] cand;
	reg [1:0]  best_lvl;
	reg [3:0]  best_slot;
	reg        found;

	// external groups sit at slots 4..8, fixed by position
	always @* begin : arb
		integer s;
		s    = 0;
		pend = {time_base_irq, timer_irq, spi_irq, greq_w, storage_card_irq,
		        usb_suspend_end_irq, usb_irq, 1'b0};
		// while halted only wake-capable sources may be served first
		cand      = cpu_halted ? (pend & `VTEI_WAKE_MASK) : pend;
		best_lvl  = cur_lvl;
		best_slot = 4'h0;
		found     = 1'b0;
		// ascending scan with strict compare: ties go to the lower slot
		for (s = 1; s < 12; s = s + 1) begin
			if (cand[s] && (prio_level(ispr_ff[2*s +: 2]) > best_lvl)) begin
				best_lvl  = prio_level(ispr_ff[2*s +: 2]);
				best_slot = s[3:0];
				found     = 1'b1;
			end
		end
	end

	// trap latches until entry; it ignores the mask entirely
	always @(posedge ref_clk) begin
		if (rst)
			trap_pend_ff <= 1'b0;
		else if (cpu_trap)
			trap_pend_ff <= 1'b1;
		else if (cpu_ack && irq_trap_ff)
			trap_pend_ff <= 1'b0;
	end

	// registered request and vector fetch address
	always @(posedge ref_clk) begin
		if (rst) begin
			irq_req_ff  <= 1'b0;
			irq_trap_ff <= 1'b0;
			irq_slot_ff <= 4'h0;
			vec_addr_ff <= {`VTEI_VEC_HI_ROM, `VTEI_VEC_LO_RESET};
			wake_ff     <= 1'b0;
		end else begin
			wake_ff <= |(pend & `VTEI_WAKE_MASK);
			if (trap_pend_ff || cpu_trap) begin
				irq_req_ff  <= 1'b1;
				irq_trap_ff <= 1'b1;
				irq_slot_ff <= 4'h0;
				vec_addr_ff <= {remap_ff ? `VTEI_VEC_HI_RAM : `VTEI_VEC_HI_ROM,
				                `VTEI_VEC_LO_TRAP};
			end else begin
				irq_req_ff  <= found;
				irq_trap_ff <= 1'b0;
				irq_slot_ff <= best_slot;
				// ram table mirrors the rom low byte in page 10h
				vec_addr_ff <= {remap_ff ? `VTEI_VEC_HI_RAM : `VTEI_VEC_HI_ROM,
				                `VTEI_VEC_LO_SLOT0 - {3'h0, best_slot, 1'b0}};
			end
		end
	end

	// ------------------------------------------------------------------------
	// condition code
	// ------------------------------------------------------------------------
	// entry beats instructions, instructions beat the bus
	always @(posedge ref_clk) begin
		if (rst) begin
			cc_ff     <= `VTEI_CC_RST;
			cc_out_ff <= `VTEI_CC_RST;
		end else begin
			cc_out_ff <= cc_ff;
			if (cpu_ack) begin
				if (irq_trap_ff) begin
					cc_ff[`VTEI_CC_HI_BIT] <= 1'b1;
					cc_ff[`VTEI_CC_LO_BIT] <= 1'b1;
				end else begin
					cc_ff[`VTEI_CC_HI_BIT] <= ispr_ff[2*irq_slot_ff + 1];
					cc_ff[`VTEI_CC_LO_BIT] <= ispr_ff[2*irq_slot_ff];
				end
			end else if (cpu_sim) begin
				cc_ff[`VTEI_CC_HI_BIT] <= 1'b1;
				cc_ff[`VTEI_CC_LO_BIT] <= 1'b1;
			end else if (cpu_rim || cpu_halt_wfi) begin
				cc_ff[`VTEI_CC_HI_BIT] <= 1'b1;
				cc_ff[`VTEI_CC_LO_BIT] <= 1'b0;
			end else if (cpu_cc_wr) begin
				cc_ff <= cpu_cc_wdata | 8'hC0;
			end else if (wr_now && addr_ff == `VTEI_OFF_CC) begin
				cc_ff <= wbyte | 8'hC0;
			end
		end
	end

endmodule
`default_nettype wire

/* rtl/vtei_map.vh */
// register offsets, reset values and vector constants for the interrupt block
`ifndef VTEI_MAP_VH
`define VTEI_MAP_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define VTEI_OFF_MISC     8'h00
`define VTEI_OFF_ISPR0    8'h04
`define VTEI_OFF_ISPR1    8'h08
`define VTEI_OFF_ISPR2    8'h0C
`define VTEI_OFF_ISPR3    8'h10
`define VTEI_OFF_EICR0    8'h14
`define VTEI_OFF_EICR1    8'h18
`define VTEI_OFF_ENA_BASE 8'h1C
`define VTEI_OFF_FLG_BASE 8'h30
`define VTEI_OFF_CC       8'h44
`define VTEI_OFF_LAST     8'h44

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define VTEI_MISC_REMAP_BIT 0
`define VTEI_CC_HI_BIT      5
`define VTEI_CC_LO_BIT      3
`define VTEI_CC_RST         8'hEA
`define VTEI_ISPR_RST       32'hFFFFFFFF
`define VTEI_ISPR3_RO_MASK  8'hF0
`define VTEI_PRIO_LVL0      2'h2
`define VTEI_PRIO_LVL3      2'h3
`define VTEI_SENS_FALL_LOW  2'h0
`define VTEI_SENS_RISE      2'h1
`define VTEI_SENS_FALL      2'h2
`define VTEI_SENS_BOTH      2'h3

// ----------------------------------------------------------------------------
// vector map
// ----------------------------------------------------------------------------
`define VTEI_VEC_HI_ROM   8'hFF
`define VTEI_VEC_HI_RAM   8'h10
`define VTEI_VEC_LO_RESET 8'hFE
`define VTEI_VEC_LO_TRAP  8'hFC
`define VTEI_VEC_LO_SLOT0 8'hFA
`define VTEI_SLOT_EXT0    4
`define VTEI_WAKE_MASK    12'h3F4

`endif

/* rtl/vtei_ext_group.v */
// one external interrupt group: pin sync, event detect, flags, request
`timescale 1ns/1ps
`default_nettype none
`include "vtei_map.vh"

module vtei_ext_group #(
	parameter W = 8
) (
	// clock and reset
	input  wire         ref_clk,
	input  wire         rst,
	// port pins, asynchronous
	input  wire [W-1:0] pins,
	// control from the register file
	input  wire [1:0]   sens,
	input  wire [W-1:0] enable,
	input  wire         flag_wr,
	input  wire [W-1:0] flag_wdata,
	input  wire         clr_all,
	// state
	output reg  [W-1:0] flags_ff,
	output wire         req
);

	reg [W-1:0] sync1_ff;
	reg [W-1:0] sync2_ff;
	reg [W-1:0] prev_ff;
	reg [W-1:0] event_w;
	reg [W-1:0] nxt_flags;

	// two-stage synchroniser, then one more stage for edge history
	always @(posedge ref_clk) begin
		if (rst) begin
			sync1_ff <= {W{1'b1}};
			sync2_ff <= {W{1'b1}};
			prev_ff  <= {W{1'b1}};
		end else begin
			sync1_ff <= pins;
			sync2_ff <= sync1_ff;
			prev_ff  <= sync2_ff;
		end
	end

	// event per pin; low level keeps firing so the flag re-sets after a clear
	always @* begin
		case (sens)
			`VTEI_SENS_FALL_LOW: event_w = ~sync2_ff;
			`VTEI_SENS_RISE:     event_w = sync2_ff & ~prev_ff;
			`VTEI_SENS_FALL:     event_w = ~sync2_ff & prev_ff;
			`VTEI_SENS_BOTH:     event_w = sync2_ff ^ prev_ff;
			default:             event_w = {W{1'b0}};
		endcase
	end

	// software writes 0 to clear; a new event in the same cycle wins
	always @* begin
		nxt_flags = flags_ff;
		if (flag_wr)
			nxt_flags = nxt_flags & flag_wdata;
		if (clr_all)
			nxt_flags = {W{1'b0}};
		nxt_flags = nxt_flags | event_w;
	end

	always @(posedge ref_clk) begin
		if (rst)
			flags_ff <= {W{1'b0}};
		else
			flags_ff <= nxt_flags;
	end

	// all pins of the port share one line, gated per pin
	assign req = |(flags_ff & enable);

endmodule
`default_nettype wire

/* verif/vtei_pin_model.sv */
// port pin model: eight pins per port, changing off the clock edge
`timescale 1ns/1ps
`default_nettype none

module vtei_pin_model (
	// clock and requested levels
	input  wire logic        ref_clk,
	input  wire logic [39:0] want,
	// pins seen by the block
	output logic      [39:0] pins
);
	// pins idle high so that release of reset shows no event
	initial pins = '1;

	// real pins are asynchronous, so they move 1 ns after the edge
	always @(posedge ref_clk) begin
		pins <= #1 want;
	end
endmodule
`default_nettype wire

/* verif/vtei_top_assertions.sv */
// concurrent checks on the ports of the interrupt block
`timescale 1ns/1ps
`default_nettype none

module vtei_top_assertions (
	// clock, reset and bus
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout_ff,
	input wire logic        hresp_ff,
	// core side
	input wire logic        cpu_ack,
	input wire logic        cpu_sim,
	input wire logic        cpu_rim,
	input wire logic        cpu_halt_wfi,
	input wire logic        irq_req_ff,
	input wire logic        irq_trap_ff,
	input wire logic [3:0]  irq_slot_ff,
	input wire logic [15:0] vec_addr_ff,
	input wire logic [7:0]  cc_out_ff
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	// bus answers: reads wait one cycle, writes none, never an error
	a_read_wait_one: assert property (
		hsel && hready && htrans[1] && !hwrite |=> !hreadyout_ff ##1 hreadyout_ff)
		else $error("read wait wrong");
	a_write_no_wait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout_ff)
		else $error("write stalled");
	a_resp_okay: assert property (hresp_ff == 1'b0) else $error("error response");
	// reset leaves the rom reset vector and level 3
	a_reset_state: assert property (
		$fell(rst) |-> vec_addr_ff == 16'hFFFE && cc_out_ff == 8'hEA && !irq_req_ff)
		else $error("reset state wrong");
	// vector address follows the slot in either table
	a_slot_vector: assert property (
		irq_req_ff && !irq_trap_ff |-> vec_addr_ff[7:0] == 8'hFA - {3'h0, irq_slot_ff, 1'b0}
		&& (vec_addr_ff[15:8] == 8'hFF || vec_addr_ff[15:8] == 8'h10))
		else $error("vector address wrong");
	a_trap_vector: assert property (
		irq_trap_ff |-> vec_addr_ff[7:0] == 8'hFC && irq_slot_ff == 4'h0)
		else $error("trap vector wrong");
	// instruction driven level changes, two cycles to reach cc_out
	a_sim_level: assert property (
		cpu_sim && !cpu_ack |=> ##1 cc_out_ff[5] && cc_out_ff[3])
		else $error("disable level wrong");
	a_rim_level: assert property (
		(cpu_rim || cpu_halt_wfi) && !cpu_ack && !cpu_sim |=> ##1 cc_out_ff[5] && !cc_out_ff[3])
		else $error("enable level wrong");
	a_cc_top_ones: assert property (cc_out_ff[7:6] == 2'b11)
		else $error("cc top bits wrong");
	// a settled level 3 masks every maskable source
	a_level3_mask: assert property (
		(cc_out_ff[5] && cc_out_ff[3])[*3] |-> !irq_req_ff || irq_trap_ff)
		else $error("level 3 not masking");
endmodule

bind vtei_top vtei_top_assertions i_chk (.ref_clk, .rst, .hsel, .htrans, .hwrite, .hready,
	.hreadyout_ff, .hresp_ff, .cpu_ack, .cpu_sim, .cpu_rim, .cpu_halt_wfi, .irq_req_ff,
	.irq_trap_ff, .irq_slot_ff, .vec_addr_ff, .cc_out_ff);
`default_nettype wire

/* verif/vector_table_and_ext_irq_bench.sv */
// self-checking bench for the interrupt vector and external interrupt block
`timescale 1ns/1ps
`default_nettype none

module vector_table_and_ext_irq_bench;
	logic        ref_clk, rst, hsel, hwrite, halted;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, rd, ex;
	logic [39:0] want;
	logic [5:0]  per;
	logic [4:0]  cpu;
	logic [7:0]  isp;
	logic [1:0]  c;
	logic        ccw;
	logic [7:0]  ccd;
	wire         hro, hresp, irq_req, irq_trap, wake;
	wire  [31:0] hrdata;
	wire  [39:0] pins;
	wire  [3:0]  slot;
	wire  [15:0] vec;
	wire  [7:0]  cc;
	int          n_fail, checks_done;

	vtei_pin_model i_pins (.ref_clk(ref_clk), .want(want), .pins(pins));
	vtei_top i_dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hro), .hreadyout_ff(hro),
		.hresp_ff(hresp), .hrdata_ff(hrdata), .ext_pins(pins), .usb_irq(per[0]),
		.usb_suspend_end_irq(per[1]), .storage_card_irq(per[2]), .spi_irq(per[3]),
		.timer_irq(per[4]), .time_base_irq(per[5]), .cpu_halted(halted), .cpu_trap(cpu[0]),
		.cpu_ack(cpu[3]), .cpu_rim(cpu[1]), .cpu_sim(cpu[2]), .cpu_halt_wfi(cpu[4]),
		.cpu_cc_wr(ccw), .cpu_cc_wdata(ccd), .irq_req_ff(irq_req), .irq_trap_ff(irq_trap),
		.irq_slot_ff(slot), .vec_addr_ff(vec), .wake_ff(wake), .cc_out_ff(cc));

	// -------------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------------
	task give_verdict;
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	// one single transfer; hready is the only pacing, the watchdog cuts hangs
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'b010;
		do @(posedge ref_clk); while (hro !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge ref_clk); while (hro !== 1'b1);
		rd = hrdata;
	endtask

	task rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	// one-cycle core pulse: {halt_wfi, ack, sim, rim, trap}
	task cpu_p(input logic [4:0] s);
		@(posedge ref_clk);
		cpu <= s;
		@(posedge ref_clk);
		cpu <= 5'h00;
	endtask

	task idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// priority write merge: the level 0 code leaves its field alone
	function automatic logic [7:0] fm(input logic [7:0] o, input logic [7:0] w);
		logic [7:0] r;
		r = w;
		for (int i = 0; i < 4; i++)
			if (w[2*i+:2] == 2'h2) r[2*i+:2] = o[2*i+:2];
		return r;
	endfunction

	// -------------------------------------------------------------------
	// clock, watchdog and tests
	// -------------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// the tests need a few hundred cycles, so 50000 means a hang
	initial begin
		#200000;
		n_fail++;
		give_verdict;
	end

	initial begin
		{rst, hsel, hwrite, halted} = 4'b1000;
		{ccw, ccd} = 9'h000;
		{haddr, htrans, hsize, hwdata} = '0;
		{want, per, cpu} = {40'hFF_FFFF_FFFF, 11'h0};
		n_fail = 0;
		checks_done = 0;
		rd = $urandom(32'hA4AB);
		idle(2);
		rst <= 1'b0;
		rchk(8'h44, 32'hEA);
		rchk(8'h04, 32'hFF);
		rchk(8'h1C, 32'h00);
		rchk(8'h48, 32'h00);
		$display("reset values done");
		bus(1'b1, 8'h04, 32'hCF);
		bus(1'b1, 8'h04, 32'h64);
		rchk(8'h04, 32'h44);
		isp = 8'h44;
		repeat (8) begin
			ex = $urandom;
			bus(1'b1, 8'h04, ex);
			isp = fm(isp, ex[7:0]);
			rchk(8'h04, {24'h0, isp});
		end
		$display("priority fields done");
		cpu_p(5'b00010);
		bus(1'b1, 8'h14, 32'h55);
		rchk(8'h14, 32'h00);
		cpu_p(5'b00100);
		// codes 1,2,3,0 so each write differs from the last and clears flags
		for (int k = 1; k < 5; k++) begin
			c = k[1:0];
			bus(1'b1, 8'h14, {30'h0, c});
			rchk(8'h30, 32'h0);
			want[0] <= 1'b0;
			idle(8);
			rchk(8'h30, {31'h0, c != 2'h1});
			want[0] <= 1'b1;
			idle(8);
			rchk(8'h30, {31'h0, c != 2'h1 || c[0]});
		end
		$display("sensitivity done");
		bus(1'b1, 8'h14, 32'h2);
		bus(1'b1, 8'h08, 32'hFD);
		bus(1'b1, 8'h0C, 32'h3F);
		cpu_p(5'b00010);
		want[0] <= 1'b0;
		idle(8);
		chk(irq_req, 1'b0);
		bus(1'b1, 8'h1C, 32'h1);
		idle(4);
		chk({irq_req, slot, vec}, {1'b1, 4'h4, 16'hFFF2});
		per[5] <= 1'b1;
		idle(4);
		chk({irq_req, slot, vec}, {1'b1, 4'hB, 16'hFFE4});
		// the ram table is taken as filled before the remap bit goes on
		bus(1'b1, 8'h00, 32'h1);
		idle(4);
		chk(vec, 16'h10E4);
		cpu_p(5'b01000);
		idle(3);
		chk({cc[5], cc[3], irq_req}, 3'b000);
		cpu_p(5'b00001);
		idle(3);
		chk({irq_trap, vec}, {1'b1, 16'h10FC});
		cpu_p(5'b01000);
		idle(3);
		chk({cc[5], cc[3]}, 2'b11);
		{per[5], want[0]} <= 2'b01;
		$display("arbitration done");
		cpu_p(5'b10000);
		idle(3);
		chk({cc[5], cc[3]}, 2'b10);
		chk({irq_req, slot}, {1'b1, 4'h4});
		// entry to an edge-mode group consumes its flags
		cpu_p(5'b01000);
		rchk(8'h30, 32'h0);
		chk({cc[5], cc[3]}, 2'b01);
		// pop of the condition code: the top two bits read back as ones
		ccd <= 8'h08;
		ccw <= 1'b1;
		@(posedge ref_clk);
		ccw <= 1'b0;
		idle(3);
		chk(cc, 32'hC8);
		halted <= 1'b1;
		bus(1'b1, 8'h30, 32'h0);
		for (int k = 0; k < 6; k++) begin
			per <= 6'h1 << k;
			idle(4);
			chk(wake, k == 1 || k == 3);
		end
		per <= 6'h0;
		bus(1'b1, 8'h20, 32'h1);
		want[8] <= 1'b0;
		idle(8);
		chk(wake, 1'b1);
		$display("halt wake done");
		give_verdict;
	end
endmodule
`default_nettype wire
